// File: tmc_pkg.sv
// shared constants of the thermal monitor and host clock register block
// assumes a 200 MHz core clock and an 8-bit register port
package tmc_pkg;

  // register indexes on the configuration port
  localparam logic [3:0] TMC_ADDR_CLK_CFG = 4'h9;
  localparam logic [3:0] TMC_ADDR_TRIM = 4'ha;
  localparam logic [3:0] TMC_ADDR_THERM_CFG = 4'hd;
  localparam logic [3:0] TMC_ADDR_THRESHOLD = 4'he;
  localparam logic [3:0] TMC_ADDR_RESULT = 4'hf;

  // field positions
  localparam int TMC_POS_TRIM_EN = 7;
  localparam int TMC_POS_DIV_LO = 1;
  localparam int TMC_POS_CLK_DIS = 0;
  localparam int TMC_POS_START = 7;
  localparam int TMC_POS_BUSY = 7;

  // values after reset
  localparam logic [2:0] TMC_RST_DIV = 3'h0;
  localparam logic TMC_RST_CLK_DIS = 1'b0;
  localparam logic TMC_RST_TRIM_EN = 1'b0;
  localparam logic [5:0] TMC_RST_TRIM = 6'h00;
  localparam logic [1:0] TMC_RST_MODE = 2'h0;
  localparam logic [5:0] TMC_RST_THRESHOLD = 6'h00;
  localparam logic [5:0] TMC_RST_RESULT = 6'h00;

  // thermal mode select codes
  localparam logic [1:0] TMC_MODE_DEFAULT = 2'h0;
  localparam logic [1:0] TMC_MODE_PROG = 2'h1;

  // divider codes
  localparam logic [2:0] TMC_DIV_3M686 = 3'h0;
  localparam logic [2:0] TMC_DIV_7M373 = 3'h1;
  localparam logic [2:0] TMC_DIV_14M74 = 3'h2;
  localparam logic [2:0] TMC_DIV_29M49 = 3'h3;
  localparam logic [2:0] TMC_DIV_1M843 = 3'h4;

  // phase increments of a 32-bit accumulator at 200 MHz
  localparam logic [31:0] TMC_INC_1M843 = 32'h025c_f6d3;
  localparam logic [31:0] TMC_INC_3M686 = 32'h04b9_eda5;
  localparam logic [31:0] TMC_INC_7M373 = 32'h0973_db4a;
  localparam logic [31:0] TMC_INC_14M74 = 32'h12e7_b695;
  localparam logic [31:0] TMC_INC_29M49 = 32'h25cf_6d29;
  // trim step divisors: -32 gives about -5 %, +31 about +6.7 %
  localparam logic [31:0] TMC_TRIM_DIV_NEG = 32'h0000_0280;
  localparam logic [31:0] TMC_TRIM_DIV_POS = 32'h0000_01cf;

  // timing
  localparam int TMC_CLK_PERIOD_PS = 5000;
  localparam int TMC_CONV_TIME_NS = 10000;
  localparam int TMC_CONV_CYCLES = (TMC_CONV_TIME_NS * 1000 + TMC_CLK_PERIOD_PS - 1) / TMC_CLK_PERIOD_PS;
  localparam int TMC_RESP_TIME_NS = 2000;
  localparam int TMC_RESP_CYCLES = (TMC_RESP_TIME_NS * 1000 + TMC_CLK_PERIOD_PS - 1) / TMC_CLK_PERIOD_PS;
  localparam logic [5:0] TMC_DEFAULT_THRESHOLD = 6'h2d;

endpackage

// File: tmc_conv.sv
// manual temperature conversion: timer, busy flag and result capture
// assumes temp_code is already synchronised to core_clk
`timescale 1ns/1ps
module tmc_conv
  import tmc_pkg::*;
(
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire logic start,
  input wire logic [5:0] temp_code,
  output logic busy_r,
  output logic done_r,
  output logic [5:0] result_r
);

  logic [11:0] cnt_r;

  // conversion timer and busy flag
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      busy_r <= 1'b0;
      cnt_r <= 12'h000;
      done_r <= 1'b0;
    end else begin
      done_r <= 1'b0;
      if (!busy_r && start) begin
        busy_r <= 1'b1;
        cnt_r <= 12'h000;
      end else if (busy_r) begin
        if (cnt_r == 12'(TMC_CONV_CYCLES - 1)) begin
          busy_r <= 1'b0;
          done_r <= 1'b1;
        end else begin
          cnt_r <= cnt_r + 12'h001;
        end
      end
    end
  end

  // result changes only at the end of a conversion
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      result_r <= TMC_RST_RESULT;
    end else if (busy_r && cnt_r == 12'(TMC_CONV_CYCLES - 1)) begin
      result_r <= temp_code;
    end
  end

  // result is held between conversions
  property p_result_hold;
    @(posedge core_clk) disable iff (sys_rst)
    !(busy_r && cnt_r == 12'(TMC_CONV_CYCLES - 1)) |=> $stable(result_r);
  endproperty
  a_result_hold: assert property (p_result_hold) else $error("result changed outside completion");

  // helper: length of the current busy stretch, for the length checks
  logic [11:0] busy_len_r;
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      busy_len_r <= 12'h000;
    end else if (busy_r) begin
      busy_len_r <= busy_len_r + 12'h001;
    end else begin
      busy_len_r <= 12'h000;
    end
  end

  // busy lasts the full conversion time and ends with done
  property p_busy_len;
    @(posedge core_clk) disable iff (sys_rst)
    $fell(busy_r) |-> busy_len_r == 12'(TMC_CONV_CYCLES) && done_r;
  endproperty
  a_busy_len: assert property (p_busy_len) else $error("conversion length wrong");

  // busy never outlasts the conversion time
  property p_busy_max;
    @(posedge core_clk) disable iff (sys_rst)
    busy_r |-> busy_len_r < 12'(TMC_CONV_CYCLES);
  endproperty
  a_busy_max: assert property (p_busy_max) else $error("conversion runs too long");

  c_conv_done: cover property (@(posedge core_clk) disable iff (sys_rst) done_r);

endmodule

// File: tmc_hclk.sv
// host clock generator: phase accumulator with divider choice and fine trim
// assumes control inputs are registers on core_clk
`timescale 1ns/1ps
module tmc_hclk
  import tmc_pkg::*;
(
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire logic [2:0] div_sel,
  input wire logic trim_en,
  input wire logic [5:0] trim_val,
  input wire logic clk_dis,
  output logic hclk_r
);

  logic [31:0] base_inc;
  logic [31:0] step;
  logic signed [39:0] adj;
  logic [31:0] inc_r;
  logic [31:0] acc_r;

  // divider code to phase increment
  function automatic logic [31:0] inc_of(input logic [2:0] sel);
    case (sel)
      TMC_DIV_7M373: inc_of = TMC_INC_7M373;
      TMC_DIV_14M74: inc_of = TMC_INC_14M74;
      TMC_DIV_29M49: inc_of = TMC_INC_29M49;
      TMC_DIV_1M843: inc_of = TMC_INC_1M843;
      default: inc_of = TMC_INC_3M686;
    endcase
  endfunction

  // signed trim offset scaled per direction
  always_comb begin
    base_inc = inc_of(div_sel);
    step = trim_val[5] ? base_inc / TMC_TRIM_DIV_NEG : base_inc / TMC_TRIM_DIV_POS;
    adj = $signed({8'h00, base_inc}) + $signed({{34{trim_val[5]}}, trim_val}) * $signed({8'h00, step});
  end

  // increment register, trim only while enabled
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      inc_r <= TMC_INC_3M686;
    end else begin
      inc_r <= trim_en ? adj[31:0] : base_inc;
    end
  end

  // accumulator and output, high while disabled
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      acc_r <= 32'h0000_0000;
      hclk_r <= 1'b1;
    end else if (clk_dis) begin
      acc_r <= 32'h0000_0000;
      hclk_r <= 1'b1;
    end else begin
      acc_r <= acc_r + inc_r;
      hclk_r <= ~acc_r[31];
    end
  end

  property p_no_trim;
    @(posedge core_clk) disable iff (sys_rst)
    !trim_en |=> inc_r == inc_of($past(div_sel));
  endproperty
  a_no_trim: assert property (p_no_trim) else $error("trim applied while disabled");

  property p_dis_high;
    @(posedge core_clk) disable iff (sys_rst)
    clk_dis [*2] |-> hclk_r;
  endproperty
  a_dis_high: assert property (p_dis_high) else $error("host clock not high while disabled");

  c_hclk_toggle: cover property (@(posedge core_clk) disable iff (sys_rst) $fell(hclk_r));

endmodule

// File: tmc_top.sv
// thermal monitor and host clock output register block
// assumes an 8-bit register port decoded from the serial configuration port
// and a 6-bit die temperature code from the analog sensor, asynchronous
//
// Overview of operation
// - programmable warning threshold applies only in thermal mode 01
// - six-bit writable threshold in bits 5:0, scaled like the result
// - temperature above threshold sets warning status and warning interrupt flag
// - programmable threshold compare has no hysteresis
// - manual conversions allowed only in thermal mode 10 or 11
// - result bit 7 reads one while converting, zero once result valid
// - six-bit unsigned result, 3 C per step, zero means -15 C
// - host clock selectable among five frequencies 1.843 to 29.49 MHz
// - fine trim acts only while trim enable is one
// - trim code signed, -32 about -5 %, +31 about +6.7 %
// - after power-up host clock runs enabled at 3.686 MHz
// - writing start begins a conversion; bit self-clears at completion
// - mode 00 uses internal default threshold; mode 1x disables warning
// - divider codes 000 to 100 select 3.686, 7.373, 14.74, 29.49, 1.843
// - host clock disable stops the clock and holds it high
`timescale 1ns/1ps
module tmc_top
  import tmc_pkg::*;
(
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [3:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata_r,
  input wire logic [5:0] die_temp_code,
  input wire logic warn_irq_clear,
  output logic thermal_warn_status_r,
  output logic thermal_warn_irq_flag_r,
  output logic host_clk_out_r
);

  // configuration registers
  logic trim_enable_r;
  logic [2:0] host_clock_divider_r;
  logic host_clock_disable_r;
  logic [5:0] clock_trim_value_r;
  logic [1:0] thermal_mode_select_r;
  logic conv_start_r;
  logic [5:0] thermal_warn_threshold_r;

  // temperature synchroniser
  logic [5:0] temp_s1_r;
  logic [5:0] temp_s2_r;
  logic [5:0] temp_s3_r;
  logic [5:0] temp_now_r;

  // warning and conversion state
  logic [9:0] resp_cnt_r;
  logic warn_cond;
  logic start_req;
  logic conv_busy;
  logic conv_done;
  logic [5:0] temperature_result;
  logic hclk;

  // write of start accepted only in manual modes and when idle
  assign start_req = reg_wr && reg_addr == TMC_ADDR_THERM_CFG && reg_wdata[TMC_POS_START]
                     && reg_wdata[1] && !conv_busy;

  // three-stage capture; a new code counts once stages two and three agree
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      temp_s1_r <= 6'h00;
      temp_s2_r <= 6'h00;
      temp_s3_r <= 6'h00;
      temp_now_r <= 6'h00;
    end else begin
      temp_s1_r <= die_temp_code;
      temp_s2_r <= temp_s1_r;
      temp_s3_r <= temp_s2_r;
      if (temp_s2_r == temp_s3_r) begin
        temp_now_r <= temp_s3_r;
      end
    end
  end

  // clock configuration registers
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      trim_enable_r <= TMC_RST_TRIM_EN;
      host_clock_divider_r <= TMC_RST_DIV;
      host_clock_disable_r <= TMC_RST_CLK_DIS;
      clock_trim_value_r <= TMC_RST_TRIM;
    end else if (reg_wr) begin
      if (reg_addr == TMC_ADDR_CLK_CFG) begin
        trim_enable_r <= reg_wdata[TMC_POS_TRIM_EN];
        host_clock_divider_r <= reg_wdata[TMC_POS_DIV_LO +: 3];
        host_clock_disable_r <= reg_wdata[TMC_POS_CLK_DIS];
      end else if (reg_addr == TMC_ADDR_TRIM) begin
        clock_trim_value_r <= reg_wdata[5:0];
      end
    end
  end

  // thermal configuration and threshold registers
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      thermal_mode_select_r <= TMC_RST_MODE;
      thermal_warn_threshold_r <= TMC_RST_THRESHOLD;
    end else if (reg_wr) begin
      if (reg_addr == TMC_ADDR_THERM_CFG) begin
        thermal_mode_select_r <= reg_wdata[1:0];
      end else if (reg_addr == TMC_ADDR_THRESHOLD) begin
        thermal_warn_threshold_r <= reg_wdata[5:0];
      end
    end
  end

  // start bit: set by an accepted write, cleared when conversion ends
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      conv_start_r <= 1'b0;
    end else if (start_req) begin
      conv_start_r <= 1'b1;
    end else if (conv_done) begin
      conv_start_r <= 1'b0;
    end
  end

  tmc_conv u_conv (
    .core_clk(core_clk),
    .sys_rst(sys_rst),
    .start(start_req),
    .temp_code(temp_now_r),
    .busy_r(conv_busy),
    .done_r(conv_done),
    .result_r(temperature_result)
  );

  tmc_hclk u_hclk (
    .core_clk(core_clk),
    .sys_rst(sys_rst),
    .div_sel(host_clock_divider_r),
    .trim_en(trim_enable_r),
    .trim_val(clock_trim_value_r),
    .clk_dis(host_clock_disable_r),
    .hclk_r(hclk)
  );

  // output copy of the host clock
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      host_clk_out_r <= 1'b1;
    end else begin
      host_clk_out_r <= hclk;
    end
  end

  // raw threshold comparison per mode, same scale as the result
  always_comb begin
    case (thermal_mode_select_r)
      TMC_MODE_PROG: warn_cond = temp_now_r > thermal_warn_threshold_r;
      TMC_MODE_DEFAULT: warn_cond = temp_now_r > TMC_DEFAULT_THRESHOLD;
      default: warn_cond = 1'b0;
    endcase
  end

  // default mode waits the response time before flagging
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      resp_cnt_r <= 10'h000;
    end else if (thermal_mode_select_r == TMC_MODE_DEFAULT && warn_cond) begin
      if (resp_cnt_r != 10'(TMC_RESP_CYCLES)) begin
        resp_cnt_r <= resp_cnt_r + 10'h001;
      end
    end else begin
      resp_cnt_r <= 10'h000;
    end
  end

  // warning status follows the compare, no hysteresis band
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      thermal_warn_status_r <= 1'b0;
    end else if (thermal_mode_select_r == TMC_MODE_PROG) begin
      thermal_warn_status_r <= warn_cond;
    end else if (thermal_mode_select_r == TMC_MODE_DEFAULT) begin
      thermal_warn_status_r <= warn_cond && resp_cnt_r == 10'(TMC_RESP_CYCLES);
    end else begin
      thermal_warn_status_r <= 1'b0;
    end
  end

  // sticky interrupt flag, a set beats a clear in the same cycle
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      thermal_warn_irq_flag_r <= 1'b0;
    end else if (thermal_warn_status_r) begin
      thermal_warn_irq_flag_r <= 1'b1;
    end else if (warn_irq_clear) begin
      thermal_warn_irq_flag_r <= 1'b0;
    end
  end

  // read data, registered on a read strobe; unmapped reads zero
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      reg_rdata_r <= 8'h00;
    end else if (reg_rd) begin
      if (reg_addr == TMC_ADDR_CLK_CFG) begin
        reg_rdata_r <= {trim_enable_r, 3'h0, host_clock_divider_r, host_clock_disable_r};
      end else if (reg_addr == TMC_ADDR_TRIM) begin
        reg_rdata_r <= {2'h0, clock_trim_value_r};
      end else if (reg_addr == TMC_ADDR_THERM_CFG) begin
        reg_rdata_r <= {conv_start_r, 5'h00, thermal_mode_select_r};
      end else if (reg_addr == TMC_ADDR_THRESHOLD) begin
        reg_rdata_r <= {2'h0, thermal_warn_threshold_r};
      end else if (reg_addr == TMC_ADDR_RESULT) begin
        reg_rdata_r <= {conv_busy, 1'b0, temperature_result};
      end else begin
        reg_rdata_r <= 8'h00;
      end
    end
  end

  // checks
  property p_prog_warn;
    @(posedge core_clk) disable iff (sys_rst)
    thermal_mode_select_r == TMC_MODE_PROG && temp_now_r > thermal_warn_threshold_r
      |=> thermal_warn_status_r ##1 thermal_warn_irq_flag_r;
  endproperty
  a_prog_warn: assert property (p_prog_warn) else $error("warning not raised above threshold");

  property p_no_hyst;
    @(posedge core_clk) disable iff (sys_rst)
    thermal_mode_select_r == TMC_MODE_PROG && temp_now_r <= thermal_warn_threshold_r |=> !thermal_warn_status_r;
  endproperty
  a_no_hyst: assert property (p_no_hyst) else $error("warning held at or below threshold");

  property p_prog_only;
    @(posedge core_clk) disable iff (sys_rst)
    thermal_mode_select_r == TMC_MODE_DEFAULT && temp_now_r <= TMC_DEFAULT_THRESHOLD |=> !thermal_warn_status_r;
  endproperty
  a_prog_only: assert property (p_prog_only) else $error("programmed threshold used outside mode 01");

  property p_manual_off;
    @(posedge core_clk) disable iff (sys_rst)
    thermal_mode_select_r[1] |=> !thermal_warn_status_r;
  endproperty
  a_manual_off: assert property (p_manual_off) else $error("warning active in manual mode");

  property p_start_mode;
    @(posedge core_clk) disable iff (sys_rst)
    $rose(conv_busy) |-> $past(reg_wdata[1]) && $past(reg_wr);
  endproperty
  a_start_mode: assert property (p_start_mode) else $error("conversion started outside manual mode");

  property p_start_clear;
    @(posedge core_clk) disable iff (sys_rst)
    conv_done |=> !conv_start_r && !conv_busy;
  endproperty
  a_start_clear: assert property (p_start_clear) else $error("start bit not cleared at completion");

  property p_defaults;
    @(posedge core_clk)
    $fell(sys_rst) |-> host_clock_divider_r == TMC_DIV_3M686 && !host_clock_disable_r;
  endproperty
  a_defaults: assert property (p_defaults) else $error("host clock defaults wrong after reset");

  property p_busy_read;
    @(posedge core_clk) disable iff (sys_rst)
    reg_rd && reg_addr == TMC_ADDR_RESULT |=> reg_rdata_r[TMC_POS_BUSY] == $past(conv_busy);
  endproperty
  a_busy_read: assert property (p_busy_read) else $error("busy bit read wrong");

  property p_flag_follows;
    @(posedge core_clk) disable iff (sys_rst)
    thermal_warn_status_r |=> thermal_warn_irq_flag_r;
  endproperty
  a_flag_follows: assert property (p_flag_follows) else $error("warning flag not set by status");

  property p_start_refused;
    @(posedge core_clk) disable iff (sys_rst)
    reg_wr && reg_addr == TMC_ADDR_THERM_CFG && !reg_wdata[1] && !conv_busy |=> !conv_busy && !conv_start_r;
  endproperty
  a_start_refused: assert property (p_start_refused) else $error("conversion started in warning mode");

  property p_result_read;
    @(posedge core_clk) disable iff (sys_rst)
    reg_rd && reg_addr == TMC_ADDR_RESULT |=> reg_rdata_r[5:0] == $past(temperature_result) && !reg_rdata_r[6];
  endproperty
  a_result_read: assert property (p_result_read) else $error("result field read wrong");

  property p_thr_read;
    @(posedge core_clk) disable iff (sys_rst)
    reg_rd && reg_addr == TMC_ADDR_THRESHOLD |=> reg_rdata_r == {2'h0, $past(thermal_warn_threshold_r)};
  endproperty
  a_thr_read: assert property (p_thr_read) else $error("threshold read wrong");

  // read data stands until the next read strobe
  property p_rdata_hold;
    @(posedge core_clk) disable iff (sys_rst)
    !reg_rd |=> $stable(reg_rdata_r);
  endproperty
  a_rdata_hold: assert property (p_rdata_hold) else $error("read data changed without a read");

  // pin copy of the host clock stays high while disabled
  property p_hclk_pin_high;
    @(posedge core_clk) disable iff (sys_rst)
    host_clock_disable_r [*3] |-> host_clk_out_r;
  endproperty
  a_hclk_pin_high: assert property (p_hclk_pin_high) else $error("host clock pin low while disabled");

  c_prog_warn: cover property (@(posedge core_clk) disable iff (sys_rst)
    thermal_mode_select_r == TMC_MODE_PROG && thermal_warn_status_r);
  c_irq_clear: cover property (@(posedge core_clk) disable iff (sys_rst) $fell(thermal_warn_irq_flag_r));

endmodule

// File: test_tmc_top.sv
// self-checking bench for the thermal monitor and host clock register block
// assumes tmc_pkg and the design files are compiled first; drives all ports directly
`timescale 1ns/1ps
module test_tmc_top;
  import tmc_pkg::*;
  localparam int TB_CEILING = 40000;
  logic core_clk = 1'b0;
  logic sys_rst = 1'b1;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [3:0] reg_addr = 4'h0;
  logic [7:0] reg_wdata = 8'h00;
  logic [7:0] reg_rdata_r;
  logic [5:0] die_temp_code = 6'h00;
  logic warn_irq_clear = 1'b0;
  logic thermal_warn_status_r;
  logic thermal_warn_irq_flag_r;
  logic host_clk_out_r;
  int mismatches = 0;
  int samples_checked = 0;
  int cycles = 0;
  int n;
  logic [7:0] rd;
  int exp16 [5] = '{868, 434, 217, 108, 1736};

  tmc_top u_tmc_top (
    .core_clk(core_clk),
    .sys_rst(sys_rst),
    .reg_wr(reg_wr),
    .reg_rd(reg_rd),
    .reg_addr(reg_addr),
    .reg_wdata(reg_wdata),
    .reg_rdata_r(reg_rdata_r),
    .die_temp_code(die_temp_code),
    .warn_irq_clear(warn_irq_clear),
    .thermal_warn_status_r(thermal_warn_status_r),
    .thermal_warn_irq_flag_r(thermal_warn_irq_flag_r),
    .host_clk_out_r(host_clk_out_r)
  );

  // 200 MHz core clock
  always #2.5 core_clk = ~core_clk;

  // hang guard
  always @(posedge core_clk) begin
    cycles <= cycles + 1;
    if (cycles == TB_CEILING) begin
      mismatches++;
      print_verdict();
    end
  end

  task automatic print_verdict();
    $display("checks %0d mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  // exact compare of design values
  task automatic check_val(input string what, input logic [7:0] expv, input logic [7:0] seen);
    samples_checked++;
    if (seen !== expv) begin
      mismatches++;
      $display("wrong value %s expected %h seen %h", what, expv, seen);
    end
  endtask

  // compare of a measured cycle count within a tolerance
  task automatic check_near(input string what, input int expv, input int seen, input int tol);
    samples_checked++;
    if (seen < expv - tol || seen > expv + tol) begin
      mismatches++;
      $display("wrong value %s expected %0d seen %0d", what, expv, seen);
    end
  endtask

  // one-cycle write strobe
  task automatic reg_write(input logic [3:0] a, input logic [7:0] d);
    @(posedge core_clk);
    #1;
    reg_wr = 1'b1;
    reg_addr = a;
    reg_wdata = d;
    @(posedge core_clk);
    #1;
    reg_wr = 1'b0;
  endtask

  // one-cycle read strobe, data taken once the register has loaded
  task automatic reg_read(input logic [3:0] a, output logic [7:0] d);
    @(posedge core_clk);
    #1;
    reg_rd = 1'b1;
    reg_addr = a;
    @(posedge core_clk);
    #1;
    reg_rd = 1'b0;
    @(posedge core_clk);
    #1;
    d = reg_rdata_r;
  endtask

  // wait a bounded number of cycles for status or flag to reach a level
  task automatic wait_flag(input bit irq, input logic val, input int maxc);
    int k;
    k = 0;
    while (k < maxc && (irq ? thermal_warn_irq_flag_r : thermal_warn_status_r) !== val) begin
      @(posedge core_clk);
      #1;
      k++;
    end
  endtask

  // core clock cycles spanned by 16 host clock periods
  // waits first so no edge of the old increment starts the count
  task automatic measure(output int cnt);
    int k;
    logic prev;
    cnt = 0;
    k = 0;
    repeat (3) @(posedge core_clk);
    #1;
    prev = host_clk_out_r;
    while (k < 17 && cnt < 8000) begin
      @(posedge core_clk);
      #1;
      cnt++;
      if (host_clk_out_r === 1'b1 && prev === 1'b0) begin
        k++;
        if (k == 1) cnt = 0;
      end
      prev = host_clk_out_r;
    end
  endtask

  initial begin
    repeat (12) @(posedge core_clk);
    #1;
    check_val("hclk in reset", 8'h01, {7'h00, host_clk_out_r});
    sys_rst = 1'b0;
    // reset values, unmapped place, read-only result
    reg_read(4'h9, rd); check_val("clk cfg reset", 8'h00, rd);
    reg_read(4'ha, rd); check_val("trim reset", 8'h00, rd);
    reg_read(4'hd, rd); check_val("mode reset", 8'h00, rd);
    reg_read(4'he, rd); check_val("threshold reset", 8'h00, rd);
    reg_read(4'hf, rd); check_val("result reset", 8'h00, rd);
    reg_write(4'h3, 8'h5a);
    reg_read(4'h3, rd); check_val("unmapped", 8'h00, rd);
    reg_write(4'he, 8'hff);
    reg_read(4'he, rd); check_val("threshold bits", 8'h3f, rd);
    reg_write(4'hf, 8'h3f);
    reg_read(4'hf, rd); check_val("result write", 8'h00, rd);
    reg_write(4'ha, 8'hff);
    reg_read(4'ha, rd); check_val("trim bits", 8'h3f, rd);
    $display("test registers done");

    // programmable threshold, no hysteresis, sticky flag
    reg_write(4'he, 8'h0a);
    reg_write(4'hd, 8'h01);
    die_temp_code = 6'h0b;
    wait_flag(1'b0, 1'b1, 12); check_val("status above", 8'h01, {7'h00, thermal_warn_status_r});
    wait_flag(1'b1, 1'b1, 3); check_val("flag above", 8'h01, {7'h00, thermal_warn_irq_flag_r});
    warn_irq_clear = 1'b1;
    @(posedge core_clk);
    #1;
    warn_irq_clear = 1'b0;
    @(posedge core_clk);
    #1;
    check_val("clear while set", 8'h01, {7'h00, thermal_warn_irq_flag_r});
    die_temp_code = 6'h0a;
    wait_flag(1'b0, 1'b0, 12); check_val("status equal", 8'h00, {7'h00, thermal_warn_status_r});
    check_val("flag sticky", 8'h01, {7'h00, thermal_warn_irq_flag_r});
    warn_irq_clear = 1'b1;
    @(posedge core_clk);
    #1;
    warn_irq_clear = 1'b0;
    wait_flag(1'b1, 1'b0, 3); check_val("flag cleared", 8'h00, {7'h00, thermal_warn_irq_flag_r});
    reg_write(4'hd, 8'h81);
    reg_read(4'hd, rd); check_val("start refused", 8'h01, rd);
    $display("test programmable warning done");

    // default threshold and response; warning off in manual mode
    die_temp_code = 6'h0b;
    reg_write(4'hd, 8'h00);
    repeat (450) @(posedge core_clk);
    #1;
    check_val("default below", 8'h00, {7'h00, thermal_warn_status_r});
    die_temp_code = 6'h2e;
    repeat (300) @(posedge core_clk);
    #1;
    check_val("default early", 8'h00, {7'h00, thermal_warn_status_r});
    wait_flag(1'b0, 1'b1, 150); check_val("default above", 8'h01, {7'h00, thermal_warn_status_r});
    die_temp_code = 6'h3f;
    reg_write(4'hd, 8'h03);
    repeat (500) @(posedge core_clk);
    #1;
    check_val("manual mode warn", 8'h00, {7'h00, thermal_warn_status_r});
    $display("test default warning done");

    // manual conversion, busy flag, self-clearing start, held result
    die_temp_code = 6'h15;
    reg_write(4'hd, 8'h82);
    reg_read(4'hf, rd); check_val("busy", 8'h80, rd);
    reg_read(4'hd, rd); check_val("start set", 8'h82, rd);
    repeat (2100) @(posedge core_clk);
    reg_read(4'hf, rd); check_val("result", 8'h15, rd);
    reg_read(4'hd, rd); check_val("start cleared", 8'h02, rd);
    die_temp_code = 6'h2a;
    repeat (50) @(posedge core_clk);
    reg_read(4'hf, rd); check_val("result held", 8'h15, rd);
    $display("test conversion done");

    // host clock frequencies, trim and disable
    for (int i = 0; i < 5; i++) begin
      reg_write(4'h9, {4'h0, i[2:0], 1'b0});
      measure(n); check_near("divider period", exp16[i], n, 3);
    end
    reg_write(4'h9, 8'h0a);
    measure(n); check_near("divider spare code", 868, n, 3);
    reg_write(4'ha, 8'h20);
    reg_write(4'h9, 8'h00);
    measure(n); check_near("trim off", 868, n, 3);
    reg_write(4'h9, 8'h80);
    measure(n); check_near("trim minus", 914, n, 4);
    reg_write(4'ha, 8'h1f);
    measure(n); check_near("trim plus", 814, n, 4);
    reg_write(4'h9, 8'h01);
    repeat (3) @(posedge core_clk);
    n = 0;
    repeat (200) begin
      @(posedge core_clk);
      #1;
      if (host_clk_out_r !== 1'b1) n++;
    end
    check_near("disabled low cycles", 0, n, 0);
    $display("test host clock done");
    print_verdict();
  end
endmodule
